// *** verilog/adcr_top.sv ***
// Processing chain configuration registers with summation and high-pass
//
// Notes on behaviour
// R1: boost runs unless boost off bit set
// R2: software writes reserved bits at reset value
// R3: summation 1 averages pairs one-two, three-four
// R4: summation 2 averages all four; 3 reserved
// R5: filter select 0 programmable stage, all-pass default
// R6: selects 1-3 fixed cutoffs; 1 after reset
// R7: ganging makes channels use channel one volume
// R8: biquad count zero to three, reset two
// R9: soft-step volume unless soft-step off bit set
// R10: software keeps gain loop master select at one
// R11: master select one enables per-channel gain loop
// R12: decimator select is plain storage, reset zero
//
// The strobed register port is this design's own decision.
`include "adcr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module adcr_top
   import adcr_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic           CLOCK_I,          // 25 MHz clock
   input  wire logic           RESET_N_I,        // Sync reset, low
   input  wire logic [7:0]     REG_ADDR_I,       // Register address
   input  wire logic [7:0]     REG_WDATA_I,      // Write data
   input  wire logic           REG_WR_I,         // Write strobe
   input  wire logic           REG_RD_I,         // Read strobe
   output logic [7:0]          REG_RDATA_O,      // Read data, next cycle
   input  wire logic           SAMPLE_VALID_I,   // Input sample strobe
   input  wire logic [4*W-1:0] SAMPLE_I,         // Channels 1..4
   input  wire logic [31:0]    CH_VOLUME_I,      // Per-channel volume
   input  wire logic [3:0]     CH_GAIN_LOOP_I,   // Per-channel gain loop
   output logic                BOOST_ON_O,       // Boost converter run
   output logic [1:0]          DECIMATOR_SEL_O,  // Decimator select
   output logic [1:0]          BIQUAD_COUNT_O,   // Biquads per channel
   output logic [3:0]          GAIN_LOOP_ON_O,   // Gain loop per channel
   output logic                SAMPLE_VALID_O,   // Output sample strobe
   output logic [4*W-1:0]      SAMPLE_O,         // Filtered channels
   output logic [31:0]         CH_GAIN_O         // Applied volume codes
);
   typedef struct packed {
      logic [7:0]     boost_config;
      logic [7:0]     dsp_config_a;
      logic [7:0]     dsp_config_b;
      logic [7:0]     gain_loop_config_a;
      logic [7:0]     rdata;
      logic           boost_on;
      logic [1:0]     decimator_select;
      logic [1:0]     biquad_count;
      logic [3:0]     gain_loop_on;
      logic           valid;
      logic [4*W-1:0] x_prev;
      logic [4*W-1:0] y;
   } adcr_top_t;

   adcr_top_t st_r;
   adcr_top_t st_nxt;

   adcr_cfg_if cfg ();

   logic           mix_valid;
   logic [4*W-1:0] mix_data;

   adcr_hpf_t           highpass_select;
   logic [15:0]         coef;
   logic signed [W+17:0] acc;
   logic signed [W+17:0] pos_lim;
   logic signed [W+17:0] neg_lim;
   logic signed [W-1:0]  xs;
   logic signed [W-1:0]  xp;
   logic signed [W-1:0]  yp;
   logic signed [W+16:0] prod;

   // Feedback coefficient of the fixed high-pass stages
   function automatic logic [15:0] coef_for(input adcr_hpf_t sel);
      logic [15:0] c;
      c = 16'h0000;
      unique case (sel)
         ADCR_HPF_CUT1: c = `ADCR_COEF_CUT1;
         ADCR_HPF_CUT2: c = `ADCR_COEF_CUT2;
         ADCR_HPF_CUT3: c = `ADCR_COEF_CUT3;
         ADCR_HPF_PROG: c = 16'h0000;
      endcase
      return c;
   endfunction

   // Configuration fields handed to the helpers
   assign cfg.sum_mode =
      adcr_sum_t'(st_r.dsp_config_a[`ADCR_POS_SUMMATION +: 2]);
   assign cfg.volume_ganging = st_r.dsp_config_b[`ADCR_BIT_GANGING];
   assign cfg.soft_step_off  = st_r.dsp_config_b[`ADCR_BIT_SOFT_OFF];

   assign highpass_select =
      adcr_hpf_t'(st_r.dsp_config_a[`ADCR_POS_HIGHPASS +: 2]);

   adcr_mixer #(
      .W        (W)
   ) u_mixer (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RESET_N_I),
      .cfg      (cfg.mix),
      .valid_i  (SAMPLE_VALID_I),
      .sample_i (SAMPLE_I),
      .valid_o  (mix_valid),
      .sample_o (mix_data)
   );

   adcr_volstep u_volstep (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RESET_N_I),
      .cfg      (cfg.vol),
      .step_i   (SAMPLE_VALID_I),
      .volume_i (CH_VOLUME_I),
      .gain_o   (CH_GAIN_O)
   );

   assign pos_lim = (W+18)'({1'b0, {(W-1){1'b1}}});
   assign neg_lim = -pos_lim - (W+18)'(1);

   always_comb begin
      st_nxt = st_r;
      coef   = coef_for(highpass_select);
      xs     = '0;
      xp     = '0;
      yp     = '0;
      prod   = '0;
      acc    = '0;

      // Register writes; read-only reserved bits stay zero
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            `ADCR_ADDR_BOOST: begin
               st_nxt.boost_config = REG_WDATA_I & `ADCR_WMASK_BOOST;
            end
            `ADCR_ADDR_DSP_A: begin
               st_nxt.dsp_config_a = REG_WDATA_I & `ADCR_WMASK_DSP_A; // R12
            end
            `ADCR_ADDR_DSP_B: begin
               st_nxt.dsp_config_b = REG_WDATA_I & `ADCR_WMASK_DSP_B;
            end
            `ADCR_ADDR_GAIN_LOOP_A: begin
               st_nxt.gain_loop_config_a =
                  REG_WDATA_I & `ADCR_WMASK_GAIN_LOOP;
            end
            default: begin
            end
         endcase
      end

      // Read data stands only in the cycle after the strobe
      st_nxt.rdata = 8'h00;
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            `ADCR_ADDR_BOOST:       st_nxt.rdata = st_r.boost_config;
            `ADCR_ADDR_DSP_A:       st_nxt.rdata = st_r.dsp_config_a;
            `ADCR_ADDR_DSP_B:       st_nxt.rdata = st_r.dsp_config_b;
            `ADCR_ADDR_GAIN_LOOP_A: st_nxt.rdata = st_r.gain_loop_config_a;
            default:                st_nxt.rdata = 8'h00;
         endcase
      end

      // Control outputs follow the stored fields
      st_nxt.boost_on =
         ~st_nxt.boost_config[`ADCR_BIT_BOOST_OFF]; // R1
      st_nxt.decimator_select =
         st_nxt.dsp_config_a[`ADCR_POS_DECIMATOR +: 2]; // R12
      st_nxt.biquad_count =
         st_nxt.dsp_config_b[`ADCR_POS_BIQUAD +: 2]; // R8
      st_nxt.gain_loop_on =
         {4{st_nxt.dsp_config_b[`ADCR_BIT_GAIN_SEL]}}
         & CH_GAIN_LOOP_I; // R11

      // First-order high-pass on each mixed channel
      st_nxt.valid = mix_valid;
      if (mix_valid) begin
         for (int i = 0; i < 4; i++) begin
            xs = $signed(mix_data[i*W +: W]);
            xp = $signed(st_r.x_prev[i*W +: W]);
            yp = $signed(st_r.y[i*W +: W]);
            if (highpass_select == ADCR_HPF_PROG) begin
               // All-pass; the programmable stage has no coefficients to load
               st_nxt.y[i*W +: W] = xs; // R5
            end else begin
               prod = yp * $signed({1'b0, coef}); // R6
               acc  = (W+18)'(xs) - (W+18)'(xp)
                    + ((W+18)'(prod) >>> `ADCR_COEF_SHIFT);
               if (acc > pos_lim) begin
                  acc = pos_lim;
               end else if (acc < neg_lim) begin
                  acc = neg_lim;
               end
               st_nxt.y[i*W +: W] = acc[W-1:0];
            end
            st_nxt.x_prev[i*W +: W] = xs;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         st_r                    <= '0;
         st_r.boost_config       <= `ADCR_RST_BOOST;
         st_r.dsp_config_a       <= `ADCR_RST_DSP_A; // R6
         st_r.dsp_config_b       <= `ADCR_RST_DSP_B; // R8
         st_r.gain_loop_config_a <= `ADCR_RST_GAIN_LOOP_A;
         st_r.boost_on           <= 1'b1;
         st_r.biquad_count       <= 2'h2;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign REG_RDATA_O     = st_r.rdata;
   assign BOOST_ON_O      = st_r.boost_on;
   assign DECIMATOR_SEL_O = st_r.decimator_select;
   assign BIQUAD_COUNT_O  = st_r.biquad_count;
   assign GAIN_LOOP_ON_O  = st_r.gain_loop_on;
   assign SAMPLE_VALID_O  = st_r.valid;
   assign SAMPLE_O        = st_r.y;
endmodule
`default_nettype wire

// *** inc/adcr_defs.svh ***
// Register offsets, field positions, reset values and filter constants
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

`define ADCR_ADDR_BOOST       8'h6A
`define ADCR_ADDR_DSP_A       8'h6B
`define ADCR_ADDR_DSP_B       8'h6C
`define ADCR_ADDR_GAIN_LOOP_A 8'h70

`define ADCR_RST_BOOST        8'h00
`define ADCR_RST_DSP_A        8'h01
`define ADCR_RST_DSP_B        8'h48
`define ADCR_RST_GAIN_LOOP_A  8'hE7

`define ADCR_WMASK_BOOST      8'hF8
`define ADCR_WMASK_DSP_A      8'h3F
`define ADCR_WMASK_DSP_B      8'hFC
`define ADCR_WMASK_GAIN_LOOP  8'hFF

`define ADCR_BIT_BOOST_OFF    7
`define ADCR_POS_DECIMATOR    4
`define ADCR_POS_SUMMATION    2
`define ADCR_POS_HIGHPASS     0
`define ADCR_BIT_GANGING      7
`define ADCR_POS_BIQUAD       5
`define ADCR_BIT_SOFT_OFF     4
`define ADCR_BIT_GAIN_SEL     3

`define ADCR_COEF_SHIFT       15
`define ADCR_COEF_CUT1        16'h7FCD
`define ADCR_COEF_CUT2        16'h7E64
`define ADCR_COEF_CUT3        16'h7991

`endif

// *** inc/adcr_pkg.sv ***
// Types shared by the configuration block and its helpers
package adcr_pkg;
   typedef enum logic [1:0] {
      ADCR_SUM_OFF,
      ADCR_SUM_PAIR,
      ADCR_SUM_QUAD,
      ADCR_SUM_RSVD
   } adcr_sum_t;

   typedef enum logic [1:0] {
      ADCR_HPF_PROG,
      ADCR_HPF_CUT1,
      ADCR_HPF_CUT2,
      ADCR_HPF_CUT3
   } adcr_hpf_t;

   typedef struct packed {
      logic [3:0][7:0] gain;
   } adcr_vol_t;
endpackage

// *** inc/adcr_cfg_if.sv ***
// Configuration carried from the register file to the helpers
`timescale 1ns/100ps
`default_nettype none
interface adcr_cfg_if;
   import adcr_pkg::*;
   adcr_sum_t sum_mode;
   logic      volume_ganging;
   logic      soft_step_off;
   modport ctrl (output sum_mode, output volume_ganging, output soft_step_off);
   modport mix  (input sum_mode);
   modport vol  (input volume_ganging, input soft_step_off);
endinterface
`default_nettype wire

// *** verilog/adcr_mixer.sv ***
// Channel summation stage for the four analog channels
`timescale 1ns/100ps
`default_nettype none
module adcr_mixer
   import adcr_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic         clk_i,    // Clock
   input  wire logic         rst_n_i,  // Sync reset, low
   adcr_cfg_if.mix           cfg,      // Summation mode
   input  wire logic         valid_i,  // Sample strobe
   input  wire logic [4*W-1:0] sample_i, // Channels 1..4
   output logic              valid_o,  // Result strobe
   output logic [4*W-1:0]    sample_o  // Mixed channels
);
   typedef struct packed {
      logic           valid;
      logic [4*W-1:0] data;
   } adcr_mix_t;

   adcr_mix_t st_r;
   adcr_mix_t st_nxt;
   logic signed [W+1:0] c [4];
   logic signed [W+1:0] pair_lo;
   logic signed [W+1:0] pair_hi;
   logic signed [W+1:0] quad;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         c[i] = (W+2)'($signed(sample_i[i*W +: W]));
      end
      pair_lo = (c[0] + c[1]) >>> 1;
      pair_hi = (c[2] + c[3]) >>> 1;
      quad    = (c[0] + c[1] + c[2] + c[3]) >>> 2;
      st_nxt = st_r;
      st_nxt.valid = valid_i;
      if (valid_i) begin
         unique case (cfg.sum_mode)
            ADCR_SUM_PAIR: begin // R3
               st_nxt.data = {pair_hi[W-1:0], pair_hi[W-1:0],
                              pair_lo[W-1:0], pair_lo[W-1:0]};
            end
            ADCR_SUM_QUAD: begin // R4
               st_nxt.data = {4{quad[W-1:0]}};
            end
            ADCR_SUM_OFF, ADCR_SUM_RSVD: begin
               st_nxt.data = sample_i;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign valid_o  = st_r.valid;
   assign sample_o = st_r.data;
endmodule
`default_nettype wire

// *** verilog/adcr_volstep.sv ***
// Volume selection with ganging and per-sample soft stepping
`timescale 1ns/100ps
`default_nettype none
module adcr_volstep
   import adcr_pkg::*;
(
   input  wire logic        clk_i,    // Clock
   input  wire logic        rst_n_i,  // Sync reset, low
   adcr_cfg_if.vol          cfg,      // Ganging and stepping
   input  wire logic        step_i,   // One step per sample
   input  wire logic [31:0] volume_i, // Per-channel volume
   output logic [31:0]      gain_o    // Applied gain codes
);
   adcr_vol_t st_r;
   adcr_vol_t st_nxt;
   logic [7:0] target [4];

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < 4; i++) begin
         target[i] = cfg.volume_ganging ? volume_i[7:0]
                                        : volume_i[i*8 +: 8]; // R7
         if (cfg.soft_step_off) begin
            st_nxt.gain[i] = target[i]; // R9
         end else if (step_i && st_r.gain[i] < target[i]) begin
            st_nxt.gain[i] = st_r.gain[i] + 8'h01; // R9
         end else if (step_i && st_r.gain[i] > target[i]) begin
            st_nxt.gain[i] = st_r.gain[i] - 8'h01; // R9
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign gain_o = st_r.gain;
endmodule
`default_nettype wire

// *** testbench/adcr_top_checker.sv ***
// Port assertions for the configuration block
`timescale 1ns/100ps
`default_nettype none
module adcr_top_checker #(
   parameter int W = 16
)(
   input wire logic           CLOCK_I,        // Clock
   input wire logic           RESET_N_I,      // Reset
   input wire logic [7:0]     REG_ADDR_I,     // Address
   input wire logic [7:0]     REG_WDATA_I,    // Write data
   input wire logic           REG_WR_I,       // Write
   input wire logic           REG_RD_I,       // Read
   input wire logic [7:0]     REG_RDATA_O,    // Read data
   input wire logic           SAMPLE_VALID_I, // Strobe in
   input wire logic           SAMPLE_VALID_O, // Strobe out
   input wire logic [4*W-1:0] SAMPLE_O,       // Samples
   input wire logic [3:0]     CH_GAIN_LOOP_I, // Loop enables
   input wire logic           BOOST_ON_O,     // Boost
   input wire logic [1:0]     DECIMATOR_SEL_O,// Decimator
   input wire logic [1:0]     BIQUAD_COUNT_O, // Biquads
   input wire logic [3:0]     GAIN_LOOP_ON_O  // Loops on
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_wr(logic [7:0] a);
      REG_WR_I && REG_ADDR_I == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      REG_RD_I && REG_ADDR_I == a;
   endsequence
   a_boost_follow: assert property (s_wr(8'h6A) |=> BOOST_ON_O == !$past(REG_WDATA_I[7]))
      else $error("boost output wrong");
   a_deci_follow: assert property (s_wr(8'h6B) |=> DECIMATOR_SEL_O == $past(REG_WDATA_I[5:4]))
      else $error("decimator output wrong");
   a_biquad_follow: assert property (s_wr(8'h6C) |=> BIQUAD_COUNT_O == $past(REG_WDATA_I[6:5]))
      else $error("biquad output wrong");
   a_rsvd_zero: assert property (s_rd(8'h6C) |=> REG_RDATA_O[1:0] == 2'h0)
      else $error("reserved bits read nonzero");
   a_valid_lat: assert property (SAMPLE_VALID_I |-> ##2 SAMPLE_VALID_O)
      else $error("sample result late");
   a_valid_only: assert property (SAMPLE_VALID_O |-> $past(SAMPLE_VALID_I, 2))
      else $error("sample result without strobe");
   a_out_hold: assert property ($changed(SAMPLE_O) |-> SAMPLE_VALID_O)
      else $error("samples changed between results");
   a_loop_mask: assert property ((GAIN_LOOP_ON_O & ~$past(CH_GAIN_LOOP_I)) == 4'h0)
      else $error("gain loop on for disabled channel");
   a_rd_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
      else $error("read data outside read cycle");
endmodule
bind adcr_top adcr_top_checker #(.W(W)) u_chk (.CLOCK_I(CLOCK_I),
   .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_VALID_O(SAMPLE_VALID_O),
   .SAMPLE_O(SAMPLE_O), .CH_GAIN_LOOP_I(CH_GAIN_LOOP_I),
   .BOOST_ON_O(BOOST_ON_O), .DECIMATOR_SEL_O(DECIMATOR_SEL_O),
   .BIQUAD_COUNT_O(BIQUAD_COUNT_O), .GAIN_LOOP_ON_O(GAIN_LOOP_ON_O));
`default_nettype wire

// *** testbench/test_adcr_top.sv ***
// Self-checking bench for the configuration registers
`include "adcr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module test_adcr_top;
   logic        clk, rst_n, wr, rd, sv, rd_q, boost, sv_o;
   logic [7:0]  addr, wd, rdat;
   logic [63:0] din, smp_o;
   logic [31:0] vol, gain;
   logic [3:0]  gl, gl_o;
   logic [1:0]  deci, biq;
   logic [15:0] r = 16'h2DD1;
   logic [7:0]  q_rd[$];
   logic [63:0] q_smp[$];
   int          n_fail = 0;
   int          samples_checked = 0;
   logic [7:0]  ad[4] = '{8'h6A, 8'h6B, 8'h6C, 8'h70};
   logic [7:0]  mk[4] = '{8'h80, 8'h3B, 8'hF8, 8'hFD};
   logic [15:0] cf[3] = '{`ADCR_COEF_CUT1, `ADCR_COEF_CUT2, `ADCR_COEF_CUT3};

   adcr_top uut (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
      .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
      .SAMPLE_VALID_I(sv), .SAMPLE_I(din), .CH_VOLUME_I(vol),
      .CH_GAIN_LOOP_I(gl), .BOOST_ON_O(boost), .DECIMATOR_SEL_O(deci),
      .BIQUAD_COUNT_O(biq), .GAIN_LOOP_ON_O(gl_o), .SAMPLE_VALID_O(sv_o),
      .SAMPLE_O(smp_o), .CH_GAIN_O(gain));

   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One bus cycle; strobes may follow with no gap
   task automatic bus(input logic w, rq, input logic [7:0] a, d, e);
      wr <= w;
      rd <= rq;
      addr <= a;
      wd <= d;
      if (rq) q_rd.push_back(e);
      @(posedge clk);
   endtask

   task automatic idle(input int n);
      repeat (n) bus(0, 0, 8'h00, 8'h00, 8'h00);
   endtask

   task automatic smp(input logic [1:0] m, input logic signed [15:0] a, b, c, d);
      logic signed [17:0] x, y, z;
      x = (a + b) >>> 1;
      y = (c + d) >>> 1;
      z = (a + b + c + d) >>> 2;
      case (m)
         2'h1: q_smp.push_back({y[15:0], y[15:0], x[15:0], x[15:0]});
         2'h2: q_smp.push_back({4{z[15:0]}});
         default: q_smp.push_back({d, c, b, a});
      endcase
      din <= {d, c, b, a};
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      @(posedge clk);
   endtask

   // Fixed high-pass step; previous input and output both equal x
   task automatic hp_smp(input logic [15:0] x, a);
      logic [47:0] p;
      p = (48'(x) * 48'(a)) >> `ADCR_COEF_SHIFT;
      q_smp.push_back({4{p[15:0]}});
      din <= {4{x}};
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      @(posedge clk);
   endtask

   // Results are compared against the oldest note
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) begin
      if (rd_q) chk("rdata", q_rd.pop_front(), rdat);
      if (sv_o) chk("sample", q_smp.pop_front(), smp_o);
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      end_sim;
   end

   initial begin
      rst_n = 0; wr = 0; rd = 0; sv = 0; addr = 0; wd = 0;
      din = 0; vol = 0; gl = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (ad[i]) bus(0, 1, ad[i], 8'h00, i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'h48 : 8'hE7);
      chk("boost", 1, boost);
      chk("biquad", 2, biq);
      foreach (ad[i]) begin
         bus(1, 0, ad[i], mk[i], 8'h00);
         bus(0, 1, ad[i], 8'h00, mk[i]);
      end
      bus(1, 0, 8'h6D, 8'hFF, 8'h00);
      bus(0, 1, 8'h6D, 8'h00, 8'h00);
      idle(1);
      chk("boost", 0, boost);
      chk("deci", 3, deci);
      chk("biquad", 3, biq);
      bus(1, 0, 8'h6A, 8'h00, 8'h00);
      idle(1);
      chk("boost", 1, boost);
      repeat (8) begin
         r = nxt(r);
         bus(1, 0, 8'h70, r[7:0] & 8'hF7, 8'h00);
         bus(1, 0, 8'h6B, r[15:8] & 8'h37, 8'h00);
         bus(0, 1, 8'h70, 8'h00, r[7:0] & 8'hF7);
         chk("deci", r[13:12], deci);
      end
      for (int k = 0; k < 4; k++) begin
         bus(1, 0, 8'h6C, {1'b0, k[1:0], 5'h08}, 8'h00);
         idle(1);
         chk("biquad", k, biq);
      end
      for (int m = 0; m < 4; m++) begin
         bus(1, 0, 8'h6B, {4'h0, 2'(m % 3), 2'h0}, 8'h00);
         idle(1);
         r = nxt(r);
         smp(2'(m % 3), r, ~r, {r[7:0], r[15:8]}, r ^ 16'h5A5A);
         idle(2);
      end
      for (int c = 1; c < 4; c++) begin
         bus(1, 0, 8'h6B, 8'h00, 8'h00);
         idle(1);
         smp(2'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
         bus(1, 0, 8'h6B, 8'(c), 8'h00);
         idle(1);
         smp(2'h0, 16'h1000, 16'h1000, 16'h1000, 16'h1000);
         hp_smp(16'h1000, cf[c-1]);
      end
      bus(1, 0, 8'h6B, 8'h00, 8'h00);
      gl <= 4'hA;
      bus(1, 0, 8'h6C, 8'h18, 8'h00);
      vol <= 32'h04030201;
      idle(2);
      chk("loop", 4'hA, gl_o);
      chk("gain", 32'h04030201, gain);
      bus(1, 0, 8'h6C, 8'h98, 8'h00);
      idle(2);
      chk("gain", 32'h01010101, gain);
      bus(1, 0, 8'h6C, 8'h88, 8'h00);
      vol <= 32'h04030204;
      idle(3);
      chk("gain", 32'h01010101, gain);
      smp(2'h3, 16'h0011, 16'h0022, 16'h0033, 16'h0044);
      chk("gain", 32'h02020202, gain);
      smp(2'h3, 16'h8000, 16'h7FFF, 16'h0001, 16'hFFFF);
      chk("gain", 32'h03030303, gain);
      idle(4);
      chk("pending", 0, q_smp.size() + q_rd.size());
      end_sim;
   end
endmodule
`default_nettype wire
